//--- design/fsl_pkg.sv
// Package for the flash suspend and lock sequencer host controller.
// Assumes a byte-wide flash with a status register read back on the data pins.
package fsl_pkg;
  // Command codes of the usual byte-wide flash command family (kept as parameters).
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'hd0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_MASTER_CONFIRM = 8'hf1;
  localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hd0;
  // Status register bit positions.
  localparam int SR_READY = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_VPP_LOW = 3;
  localparam int SR_SUSPENDED = 2;
  localparam int SR_LOCK_VIOL = 1;
  // Bus timing: each strobe phase lasts this long.
  localparam int PHASE_NS = 50;
  localparam int CLK_NS = 10;
  localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
  localparam int ADDR_W = 20;
  // User operations.
  typedef enum logic [2:0] {
    FSL_OP_SUSPEND = 3'h0,
    FSL_OP_RESUME = 3'h1,
    FSL_OP_SET_BLOCK = 3'h2,
    FSL_OP_SET_MASTER = 3'h3,
    FSL_OP_CLEAR_LOCKS = 3'h4,
    FSL_OP_CLEAR_STATUS = 3'h5,
    FSL_OP_READ_STATUS = 3'h6
  } fsl_op_t;
  typedef enum logic [2:0] {
    FSL_IDLE = 3'b000,
    FSL_WR1 = 3'b001,
    FSL_WR2 = 3'b011,
    FSL_POLL = 3'b010,
    FSL_DONE = 3'b110
  } fsl_state_t;
  // Flash pin group driven by the controller.
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } fsl_pins_t;
endpackage

//--- design/fsl_host.sv
// Host controller that issues suspend, resume and lock-bit sequences to a byte-wide flash.
// Assumes the flash pins are synchronous to sys_clk and the write state machine answers
// through its status register and ready_busy_output.
//
// Notes on behaviour
// - While suspended, send only status, resume.
// - Lock set is setup then confirm cycle.
// - Check write error flag after lock set.
// - Check erase error flag after clear.
// - Aborted clear leaves bits unknown; repeat it.
// - Error flags cleared only by clear status.
`timescale 1ns/1ns
module fsl_host
  import fsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire fsl_op_t op_code,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic override_req,
  output logic op_ready,
  output logic done,
  output logic [7:0] status,
  output logic error,
  output logic refused,
  output logic suspended,
  output logic locks_unknown,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  input wire logic ready_busy_output,
  output logic reset_powerdown_pin_hh
);

  typedef struct packed {
    fsl_state_t st;
    fsl_op_t op;
    logic [3:0] cnt;
    logic [1:0] phase;
    logic [7:0] cmd2;
    logic two;
    logic poll;
    fsl_pins_t pins;
    logic done;
    logic [7:0] status;
    logic error;
    logic refused;
    logic suspended;
    logic locks_unknown;
    logic hh;
    logic ready;
  } fsl_reg_t;

  fsl_reg_t r;
  fsl_reg_t next_r;

  // Sequencer: each bus cycle is a setup, strobe and hold phase of PHASE_CYC clocks.
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.refused = 1'b0;
    unique case (r.st)
      FSL_IDLE:
      begin
        next_r.pins.ce_n = 1'b1;
        next_r.pins.we_n = 1'b1;
        next_r.pins.oe_n = 1'b1;
        next_r.pins.dq_oe = 1'b0;
        if (op_valid && r.ready)
        begin
          next_r.op = op_code;
          next_r.pins.addr = op_addr;
          next_r.two = 1'b0;
          next_r.poll = 1'b1;
          next_r.cnt = PHASE_CYC;
          next_r.phase = 2'h0;
          next_r.st = FSL_WR1;
          unique case (op_code)
            FSL_OP_SUSPEND: next_r.pins.dq_out = CMD_SUSPEND;
            FSL_OP_RESUME: next_r.pins.dq_out = CMD_RESUME;
            FSL_OP_READ_STATUS: next_r.pins.dq_out = CMD_READ_STATUS;
            FSL_OP_CLEAR_STATUS:
            begin
              next_r.pins.dq_out = CMD_CLEAR_STATUS;
              next_r.poll = 1'b0;
            end
            FSL_OP_SET_BLOCK:
            begin
              next_r.pins.dq_out = CMD_LOCK_SETUP;
              next_r.cmd2 = CMD_BLOCK_CONFIRM;
              next_r.two = 1'b1;
            end
            FSL_OP_SET_MASTER:
            begin
              next_r.pins.dq_out = CMD_LOCK_SETUP;
              next_r.cmd2 = CMD_MASTER_CONFIRM;
              next_r.two = 1'b1;
            end
            FSL_OP_CLEAR_LOCKS:
            begin
              next_r.pins.dq_out = CMD_LOCK_SETUP;
              next_r.cmd2 = CMD_CLEAR_CONFIRM;
              next_r.two = 1'b1;
            end
            default: next_r.st = FSL_IDLE;
          endcase
          // While suspended only status and resume are sent; clear status has no effect.
          if (r.suspended && op_code != FSL_OP_RESUME && op_code != FSL_OP_READ_STATUS)
          begin
            next_r.st = FSL_IDLE;
            next_r.refused = 1'b1;
            next_r.done = 1'b1;
          end
          // Override voltage is applied only for lock changes that need it; a refused
          // request must not move the reset pin level that a suspended write relies on.
          next_r.hh = override_req && !r.suspended && (op_code == FSL_OP_SET_BLOCK
            || op_code == FSL_OP_SET_MASTER || op_code == FSL_OP_CLEAR_LOCKS);
        end
      end
      FSL_WR1, FSL_WR2:
      begin
        next_r.pins.dq_oe = 1'b1;
        next_r.pins.ce_n = 1'b0;
        next_r.pins.we_n = (r.phase != 2'h1);
        if (r.cnt > 4'h1)
          next_r.cnt = r.cnt - 4'h1;
        else
        begin
          next_r.cnt = PHASE_CYC;
          next_r.phase = r.phase + 2'h1;
          if (r.phase == 2'h2)
          begin
            next_r.phase = 2'h0;
            next_r.pins.ce_n = 1'b1;
            next_r.pins.dq_oe = 1'b0;
            if (r.st == FSL_WR1 && r.two)
            begin
              next_r.st = FSL_WR2;
              next_r.pins.dq_out = r.cmd2;
            end
            else if (r.poll)
              next_r.st = FSL_POLL;
            else
            begin
              next_r.st = FSL_DONE;
              next_r.status = 8'h00;
            end
          end
        end
      end
      FSL_POLL:
      begin
        // Status is read with output enable; each read restarts the latch.
        next_r.pins.dq_oe = 1'b0;
        next_r.pins.we_n = 1'b1;
        next_r.pins.ce_n = 1'b0;
        next_r.pins.oe_n = (r.phase != 2'h1);
        if (r.cnt > 4'h1)
          next_r.cnt = r.cnt - 4'h1;
        else
        begin
          next_r.cnt = PHASE_CYC;
          next_r.phase = r.phase + 2'h1;
          if (r.phase == 2'h1)
            next_r.status = flash_dq_in;
          if (r.phase == 2'h2)
          begin
            next_r.phase = 2'h0;
            next_r.pins.ce_n = 1'b1;
            if (r.status[SR_READY] && ready_busy_output)
              next_r.st = FSL_DONE;
          end
        end
      end
      FSL_DONE:
      begin
        next_r.done = 1'b1;
        next_r.hh = 1'b0;
        next_r.st = FSL_IDLE;
        if (r.op == FSL_OP_SUSPEND)
          next_r.suspended = r.status[SR_SUSPENDED];
        if (r.op == FSL_OP_RESUME)
          next_r.suspended = 1'b0;
        // Errors reported after lock operations, low supply and violations included.
        next_r.error = r.status[SR_WRITE_ERR] || r.status[SR_ERASE_ERR]
          || r.status[SR_LOCK_VIOL] || r.status[SR_VPP_LOW];
        if (r.op == FSL_OP_CLEAR_LOCKS)
          next_r.locks_unknown = 1'b0;
      end
      default: next_r.st = FSL_IDLE;
    endcase
    // Ready is registered so that the output comes straight from a flip-flop.
    next_r.ready = (next_r.st == FSL_IDLE) && !next_r.done;
  end

  // State register; a reset during a lock clear leaves lock bits undefined.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.pins.ce_n <= 1'b1;
      r.pins.we_n <= 1'b1;
      r.pins.oe_n <= 1'b1;
      r.st <= FSL_IDLE;
      r.ready <= 1'b1;
      r.locks_unknown <= (r.op == FSL_OP_CLEAR_LOCKS && r.st != FSL_IDLE) || r.locks_unknown;
    end
    else
      r <= next_r;
  end

  assign op_ready = r.ready;
  assign done = r.done;
  assign status = r.status;
  assign error = r.error;
  assign refused = r.refused;
  assign suspended = r.suspended;
  assign locks_unknown = r.locks_unknown;
  assign flash_ce_n = r.pins.ce_n;
  assign flash_we_n = r.pins.we_n;
  assign flash_oe_n = r.pins.oe_n;
  assign flash_addr = r.pins.addr;
  assign flash_dq_out = r.pins.dq_out;
  assign flash_dq_oe = r.pins.dq_oe;
  assign reset_powerdown_pin_hh = r.hh;

  AST_WE_ONLY_WHEN_DRIVING: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flash_we_n |-> flash_dq_oe && !flash_ce_n) else $error("write strobe without data");
  AST_NO_CLEAR_IN_SUSPEND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.suspended && r.st == FSL_WR1) |-> flash_dq_out != CMD_CLEAR_STATUS)
    else $error("clear status sent while suspended");
  AST_SUSPEND_REFUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op_valid && op_ready && r.st == FSL_IDLE && r.suspended && op_code == FSL_OP_SET_BLOCK)
    |=> refused && r.st == FSL_IDLE) else $error("lock set not refused in suspend");
  AST_SECOND_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(r.st == FSL_WR2)) |-> flash_dq_out == r.cmd2) else $error("bad confirm code");
  AST_POLL_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(r.st == FSL_DONE) && $past(r.st) == FSL_POLL) |-> r.status[SR_READY])
    else $error("finished without ready flag");
  AST_HH_ONLY_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_powerdown_pin_hh |-> r.op inside {FSL_OP_SET_BLOCK, FSL_OP_SET_MASTER,
    FSL_OP_CLEAR_LOCKS}) else $error("override outside lock operation");
  AST_DONE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done |=> !done) else $error("done longer than one cycle");
  AST_RESUME_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == FSL_DONE && r.op == FSL_OP_RESUME) |=> !suspended)
    else $error("suspended still set after resume");

endmodule // fsl_host

//--- tb/fsl_flash_model.sv
// Behavioural byte-wide flash: status register, lock bits and byte write suspend.
// Assumes pins synchronous to sys_clk and the command codes of fsl_pkg.
`timescale 1ns/1ns
module fsl_flash_model
  import fsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire fsl_pins_t pins,
  input wire logic rp_hh,
  input wire logic write_start,
  input wire logic supply_low,
  output logic [7:0] dq_in,
  output logic ready_busy
);
  logic [7:0] sr, last, busy, held;
  // Lock bits are non-volatile: reset leaves them alone, so they start cleared here.
  logic [15:0] blk = 16'h0000;
  logic master = 1'b0;
  logic setup, susp, we_q, wr_edge;
  assign wr_edge = !we_q && pins.we_n && !pins.ce_n && pins.dq_oe;
  // Released data lines show the inverse of the last value, never a stale copy.
  assign dq_in = (!pins.ce_n && !pins.oe_n) ? sr : ~last;
  assign ready_busy = sr[7];
  // Commands latch on the rising write strobe; reset stands in for power-up but keeps locks.
  always_ff @(posedge sys_clk)
  begin
    we_q <= pins.we_n;
    last <= dq_in;
    if (!rst_n)
    begin
      sr <= 8'h80;
      {busy, held, setup, susp} <= '0;
    end
    else
    begin
      if (busy != 8'h00)
      begin
        busy <= busy - 8'h01;
        sr[7] <= (busy == 8'h01);
      end
      // A byte write into a locked block is refused unless override voltage is applied.
      if (write_start && blk[pins.addr[19:16]] && !rp_hh)
        sr <= sr | 8'h12;
      else if (write_start)
      begin
        busy <= 8'hc8;
        sr[7] <= 1'b0;
      end
      if (wr_edge && setup)
      begin
        setup <= 1'b0;
        busy <= 8'h1e;
        sr[7] <= 1'b0;
        // Master lock is never cleared here, only ever set.
        case (pins.dq_out)
          CMD_BLOCK_CONFIRM: if (master && !rp_hh) sr <= (sr & 8'h7f) | 8'h12;
            else blk[pins.addr[19:16]] <= 1'b1;
          CMD_MASTER_CONFIRM: if (!rp_hh) sr <= (sr & 8'h7f) | 8'h12;
            else master <= 1'b1;
          CMD_CLEAR_CONFIRM:
          begin
            if (supply_low)
              sr <= (sr & 8'h7f) | 8'h28;
            else if (master && !rp_hh)
              sr <= (sr & 8'h7f) | 8'h22;
            else
              blk <= 16'h0000;
          end
          default: sr <= (sr & 8'h7f) | 8'h30;
        endcase
      end
      else if (wr_edge && susp)
      begin
        // Only resume is acted on; clear status is ignored while suspended.
        if (pins.dq_out == CMD_RESUME)
        begin
          susp <= 1'b0;
          busy <= held;
          sr <= sr & 8'h7b;
        end
      end
      else if (wr_edge && pins.dq_out == CMD_LOCK_SETUP)
        setup <= 1'b1;
      else if (wr_edge && pins.dq_out == CMD_CLEAR_STATUS)
        sr <= sr & 8'hc5;
      else if (wr_edge && pins.dq_out == CMD_SUSPEND && busy != 8'h00)
      begin
        susp <= 1'b1;
        held <= busy;
        busy <= 8'h00;
        sr <= sr | 8'h84;
      end
    end
  end
endmodule // fsl_flash_model

//--- tb/flash_suspend_and_lock_sequencer_tb_top.sv
// Self-checking testbench for the flash suspend and lock host controller.
// Assumes fsl_pkg, fsl_host and fsl_flash_model are compiled before it.
`timescale 1ns/1ns
module flash_suspend_and_lock_sequencer_tb_top;
  import fsl_pkg::*;
  logic sys_clk = 0, rst_n = 0, op_valid = 0, override_req = 0, write_start = 0;
  logic supply_low = 0;
  fsl_op_t op_code = FSL_OP_READ_STATUS;
  logic [ADDR_W-1:0] op_addr = '0, flash_addr;
  logic op_ready, done, error, refused, suspended, locks_unknown, ref_seen;
  logic ce_n, we_n, oe_n, dq_oe, rdy, hh;
  logic [7:0] status, dq_out, dq_in;
  fsl_pins_t pins;
  int err_total = 0, comparisons = 0;
  assign pins = {ce_n, we_n, oe_n, flash_addr, dq_out, dq_oe};
  always #5 sys_clk = ~sys_clk;
  fsl_host i_fsl_host (.sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .override_req(override_req), .op_ready(op_ready),
    .done(done), .status(status), .error(error), .refused(refused), .suspended(suspended),
    .locks_unknown(locks_unknown), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in), .ready_busy_output(rdy), .reset_powerdown_pin_hh(hh));
  fsl_flash_model i_fsl_flash_model (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins),
    .rp_hh(hh), .write_start(write_start), .supply_low(supply_low), .dq_in(dq_in),
    .ready_busy(rdy));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds the request until taken, then waits a bounded time for done.
  task automatic run_op(input fsl_op_t op, input logic [ADDR_W-1:0] a, input logic ovr);
    int n;
    n = 0;
    op_valid <= 1'b1;
    op_code <= op;
    op_addr <= a;
    override_req <= ovr;
    do @(posedge sys_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (done !== 1'b1 && n < 3000);
    check("done", 16'(n < 3000), 16'h1);
    ref_seen = refused;
  endtask
  // One-cycle request to the model to start an internal byte write.
  task automatic pulse_write();
    write_start <= 1'b1;
    @(posedge sys_clk);
    write_start <= 1'b0;
  endtask
  task automatic t_set_locks();
    run_op(FSL_OP_SET_BLOCK, 20'h10000, 1'b0);
    check("status", status, 16'h80);
    run_op(FSL_OP_SET_MASTER, 20'h0, 1'b0);
    check("status", status, 16'h92);
    check("error", error, 16'h1);
    run_op(FSL_OP_CLEAR_STATUS, 20'h0, 1'b0);
    run_op(FSL_OP_READ_STATUS, 20'h0, 1'b0);
    check("status", status, 16'h80);
    run_op(FSL_OP_SET_MASTER, 20'h0, 1'b1);
    check("master", i_fsl_flash_model.master, 16'h1);
    run_op(FSL_OP_SET_BLOCK, 20'h20000, 1'b0);
    check("status", status, 16'h92);
    run_op(FSL_OP_CLEAR_STATUS, 20'h0, 1'b0);
    run_op(FSL_OP_SET_BLOCK, 20'h20000, 1'b1);
    check("blocks", i_fsl_flash_model.blk, 16'h0006);
    pulse_write();
    run_op(FSL_OP_READ_STATUS, 20'h0, 1'b0);
    check("status", status, 16'h92);
    run_op(FSL_OP_CLEAR_STATUS, 20'h0, 1'b0);
    $display("test set_locks finished");
  endtask
  task automatic t_clear_locks();
    run_op(FSL_OP_CLEAR_LOCKS, 20'h0, 1'b0);
    check("status", status, 16'ha2);
    run_op(FSL_OP_CLEAR_STATUS, 20'h0, 1'b0);
    supply_low <= 1'b1;
    run_op(FSL_OP_CLEAR_LOCKS, 20'h0, 1'b1);
    supply_low <= 1'b0;
    check("status", status, 16'ha8);
    check("error", error, 16'h1);
    check("blocks", i_fsl_flash_model.blk, 16'h0006);
    run_op(FSL_OP_CLEAR_STATUS, 20'h0, 1'b0);
    run_op(FSL_OP_CLEAR_LOCKS, 20'h0, 1'b1);
    check("blocks", i_fsl_flash_model.blk, 16'h0);
    check("master", i_fsl_flash_model.master, 16'h1);
    check("unknown", locks_unknown, 16'h0);
    $display("test clear_locks finished");
  endtask
  task automatic t_suspend();
    pulse_write();
    run_op(FSL_OP_SUSPEND, 20'h0, 1'b0);
    check("status", status, 16'h84);
    check("suspended", suspended, 16'h1);
    run_op(FSL_OP_CLEAR_STATUS, 20'h0, 1'b0);
    check("refused", ref_seen, 16'h1);
    run_op(FSL_OP_SET_BLOCK, 20'h0, 1'b1);
    check("refused", ref_seen, 16'h1);
    check("override", hh, 16'h0);
    run_op(FSL_OP_RESUME, 20'h0, 1'b0);
    check("status", status, 16'h80);
    check("suspended", suspended, 16'h0);
    $display("test suspend finished");
  endtask
  // A reset in the middle of a lock clear marks the locks unknown until a clear is repeated.
  task automatic t_abort_clear();
    op_valid <= 1'b1;
    op_code <= FSL_OP_CLEAR_LOCKS;
    op_addr <= 20'h0;
    override_req <= 1'b1;
    do @(posedge sys_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check("unknown", locks_unknown, 16'h1);
    check("master", i_fsl_flash_model.master, 16'h1);
    run_op(FSL_OP_CLEAR_LOCKS, 20'h0, 1'b1);
    check("unknown", locks_unknown, 16'h0);
    check("status", status, 16'h80);
    $display("test abort_clear finished");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_set_locks();
    t_clear_locks();
    t_suspend();
    t_abort_clear();
    finish_test();
  end
  // The whole run needs about a thousand cycles; this limit leaves ample margin.
  initial
  begin
    #300000;
    err_total++;
    finish_test();
  end
endmodule // flash_suspend_and_lock_sequencer_tb_top
